// File: src/orc_params.svh
`ifndef ORC_PARAMS_SVH
`define ORC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
// Page that holds the routing register
`define ORC_REG_PAGE 4'h2
// Offset of output_routing_control within its page
`define ORC_REG_ADDR 6'h20

// ----------------------------------------------------------------------------
// Reset and read-back
// ----------------------------------------------------------------------------
// Both mute bits set, everything else clear
`define ORC_REG_RESET 16'h0006
// Write-only protection bit is hidden on reads
`define ORC_READ_MASK 16'hFFFE
// Value returned for an address that is not this register
`define ORC_READ_NONE 16'h0000

// ----------------------------------------------------------------------------
// DAC source codes
// ----------------------------------------------------------------------------
`define ORC_DAC_NONE 2'h0
`define ORC_DAC_LEFT 2'h1
`define ORC_DAC_RIGHT 2'h2
`define ORC_DAC_AVG 2'h3

`endif

// File: src/orc_pkg.sv
package orc_pkg;

  // --------------------------------------------------------------------------
  // Register layout, most significant field first
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic differential_mode_select;
    logic [1:0] dac_route_first_out;
    logic sidetone_route_first_out;
    logic buzzer_route_first_out;
    logic keyclick_route_first_out;
    logic cellin_route_first_out;
    logic [1:0] dac_route_second_out;
    logic sidetone_route_second_out;
    logic buzzer_route_second_out;
    logic keyclick_route_second_out;
    logic cellin_route_second_out;
    logic first_out_mute;
    logic second_out_mute;
    logic headphone_short_protect_disable;
  } orc_ctrl_t;

  // --------------------------------------------------------------------------
  // Switch settings for one driver's summing node
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic dac_left;
    logic dac_right;
    logic dac_avg;
    logic sidetone;
    logic buzzer;
    logic keyclick;
    logic cellin;
    logic mute;
  } orc_route_t;

endpackage : orc_pkg

// File: src/orc_output_routing.sv
`timescale 1ns/1ps
`default_nettype none
`include "orc_params.svh"

// Operation
// [R01] Top bit picks single-ended or differential outputs
// [R02] Differential pair unpowered forces both drivers down
// [R03] Two bits pick DAC source, first output
// [R04] Sidetone to first output when set
// [R05] Buzzer stage to first output when set
// [R06] Keyclick to first output when set
// [R07] Cell-phone input to first output when set
// [R08] Two bits pick DAC source, second output; in differential mode the code forces it to no DAC source
// [R09] Sidetone to second output, single-ended only
// [R10] Buzzer stage to second output, single-ended only
// [R11] Keyclick to second output, single-ended only
// [R12] Cell-phone input to second output, single-ended only
// [R13] First output mute, resets to muted
// [R14] Second output mute, resets to muted
// [R15] Write-only headphone protection disable, resets enabled
// [R16] Reads return fields, protection bit reads zero
module orc_output_routing #(
  parameter int ADDR_W = 6, // Register offset width
  parameter int PAGE_W = 4  // Register page width
) (
  input wire logic ref_clk,
  input wire logic srst,
  // Register access port from the serial host decoder
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [PAGE_W-1:0] page,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Power state of the drivers, from the analog side
  input wire logic first_pwr_up,
  input wire logic aux_pwr_up,
  // Driver controls
  output orc_pkg::orc_route_t first_route,
  output orc_pkg::orc_route_t second_route,
  output logic diff_mode,
  output logic pair_power_down,
  output logic hp_short_protect_disable
);

  // --------------------------------------------------------------------------
  // Storage and helpers
  // --------------------------------------------------------------------------
  orc_pkg::orc_ctrl_t ctrl; // The control register itself
  logic hit; // Access targets this register
  logic first_pwr_s1; // First sync stage, read only by stage two
  logic first_pwr_s2; // Synchronised first driver power
  logic aux_pwr_s1; // First sync stage, read only by stage two
  logic aux_pwr_s2; // Synchronised aux driver power

  // Builds the switch settings of one driver from its fields
  function automatic orc_pkg::orc_route_t route_of(
    input logic [1:0] dac,
    input logic ast,
    input logic buz,
    input logic kcl,
    input logic cpi,
    input logic mute
  );
    orc_pkg::orc_route_t r;
    r = '0;
    r.dac_left = (dac == `ORC_DAC_LEFT);
    r.dac_right = (dac == `ORC_DAC_RIGHT);
    r.dac_avg = (dac == `ORC_DAC_AVG);
    r.sidetone = ast;
    r.buzzer = buz;
    r.keyclick = kcl;
    r.cellin = cpi;
    r.mute = mute;
    return r;
  endfunction : route_of

  // Page and offset both match
  assign hit = (page == `ORC_REG_PAGE) && (addr == `ORC_REG_ADDR);

  // --------------------------------------------------------------------------
  // Register write
  // --------------------------------------------------------------------------
  // Whole word is taken; the protection bit is kept though never read back
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= orc_pkg::orc_ctrl_t'(`ORC_REG_RESET); // [R13] [R14] [R15]
    end else if (wr_en && hit) begin
      ctrl <= orc_pkg::orc_ctrl_t'(wr_data);
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  // One cycle latency; a miss answers zero so the host never stalls
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data <= `ORC_READ_NONE;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en && hit) begin
        rd_data <= 16'(ctrl) & `ORC_READ_MASK; // [R16] [R15]
      end else if (rd_en) begin
        rd_data <= `ORC_READ_NONE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power status synchronisers
  // --------------------------------------------------------------------------
  // Power-good levels come from analog, so they are resynchronised
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      first_pwr_s1 <= 1'b0;
      first_pwr_s2 <= 1'b0;
      aux_pwr_s1 <= 1'b0;
      aux_pwr_s2 <= 1'b0;
    end else begin
      first_pwr_s1 <= first_pwr_up;
      first_pwr_s2 <= first_pwr_s1;
      aux_pwr_s1 <= aux_pwr_up;
      aux_pwr_s2 <= aux_pwr_s1;
    end
  end

  // --------------------------------------------------------------------------
  // Mode and pair protection
  // --------------------------------------------------------------------------
  // A half-powered differential pair would drive a lopsided load,
  // so both halves are shut down until both report powered
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      diff_mode <= 1'b0;
      pair_power_down <= 1'b0;
    end else begin
      diff_mode <= ctrl.differential_mode_select; // [R01]
      pair_power_down <= ctrl.differential_mode_select
        && !(first_pwr_s2 && aux_pwr_s2); // [R02]
    end
  end

  // --------------------------------------------------------------------------
  // First driver routing
  // --------------------------------------------------------------------------
  // Serves the first driver alone or the differential pair alike
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      first_route <= route_of(`ORC_DAC_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    end else begin
      first_route <= route_of(
        ctrl.dac_route_first_out, // [R03]
        ctrl.sidetone_route_first_out, // [R04]
        ctrl.buzzer_route_first_out, // [R05]
        ctrl.keyclick_route_first_out, // [R06]
        ctrl.cellin_route_first_out, // [R07]
        ctrl.first_out_mute); // [R13]
    end
  end

  // --------------------------------------------------------------------------
  // Second driver routing
  // --------------------------------------------------------------------------
  // In differential mode the second driver is unused: all sources off and
  // muted, while the stored fields survive for a return to single-ended
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      second_route <= route_of(`ORC_DAC_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    end else if (ctrl.differential_mode_select) begin
      second_route <= route_of(`ORC_DAC_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    end else begin
      second_route <= route_of(
        ctrl.dac_route_second_out, // [R08]
        ctrl.sidetone_route_second_out, // [R09]
        ctrl.buzzer_route_second_out, // [R10]
        ctrl.keyclick_route_second_out, // [R11]
        ctrl.cellin_route_second_out, // [R12]
        ctrl.second_out_mute); // [R14]
    end
  end

  // --------------------------------------------------------------------------
  // Headphone protection control
  // --------------------------------------------------------------------------
  // Zero keeps short-circuit protection on
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hp_short_protect_disable <= 1'b0;
    end else begin
      hp_short_protect_disable <= ctrl.headphone_short_protect_disable; // [R15]
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // A write shows on the mode output two edges later
  mode_follow_a: assert property (@(posedge ref_clk) disable iff (srst) // [R01]
    wr_en && hit ##1 !srst |=> diff_mode == $past(wr_data[15], 2))
    else $error("diff_mode does not follow written mode bit");

  // Pair shuts down while mode set and a half is unpowered
  pair_down_a: assert property (@(posedge ref_clk) disable iff (srst) // [R02]
    ctrl.differential_mode_select && !(first_pwr_s2 && aux_pwr_s2)
    |=> pair_power_down)
    else $error("pair not powered down");

  // Never shut down in single-ended mode
  pair_single_a: assert property (@(posedge ref_clk) disable iff (srst) // [R02]
    !ctrl.differential_mode_select |=> !pair_power_down)
    else $error("pair powered down in single-ended mode");

  // Average code enables only the average path
  first_avg_a: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
    ctrl.dac_route_first_out == `ORC_DAC_AVG
    |=> first_route.dac_avg && !first_route.dac_left && !first_route.dac_right)
    else $error("first output average source wrong");

  // Left code enables only the left path
  first_left_a: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
    ctrl.dac_route_first_out == `ORC_DAC_LEFT
    |=> first_route.dac_left && !first_route.dac_right && !first_route.dac_avg)
    else $error("first output left source wrong");

  // None code leaves every DAC path of the first output open
  first_none_a: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
    ctrl.dac_route_first_out == `ORC_DAC_NONE
    |=> !first_route.dac_left && !first_route.dac_right && !first_route.dac_avg)
    else $error("first output DAC not disconnected");

  // Right code enables only the right path
  first_right_a: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
    ctrl.dac_route_first_out == `ORC_DAC_RIGHT
    |=> first_route.dac_right && !first_route.dac_left && !first_route.dac_avg)
    else $error("first output right source wrong");

  // Analog sources follow their bits on the first output
  first_analog_a: assert property (@(posedge ref_clk) disable iff (srst) // [R04]
    1'b1 |=> first_route.sidetone == $past(ctrl.sidetone_route_first_out)
      && first_route.buzzer == $past(ctrl.buzzer_route_first_out) // [R05]
      && first_route.keyclick == $past(ctrl.keyclick_route_first_out) // [R06]
      && first_route.cellin == $past(ctrl.cellin_route_first_out)) // [R07]
    else $error("first output analog routing mismatch");

  // Right code in single-ended mode reaches the second output
  second_right_a: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
    !ctrl.differential_mode_select
    && ctrl.dac_route_second_out == `ORC_DAC_RIGHT
    |=> second_route.dac_right && !second_route.dac_left)
    else $error("second output right source wrong");

  // Left code in single-ended mode lights only the left path
  second_left_a: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
    !ctrl.differential_mode_select
    && ctrl.dac_route_second_out == `ORC_DAC_LEFT
    |=> second_route.dac_left && !second_route.dac_right && !second_route.dac_avg)
    else $error("second output left source wrong");

  // Average code in single-ended mode lights only the average path
  second_avg_a: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
    !ctrl.differential_mode_select
    && ctrl.dac_route_second_out == `ORC_DAC_AVG
    |=> second_route.dac_avg && !second_route.dac_left && !second_route.dac_right)
    else $error("second output average source wrong");

  // Second output analog sources track bits in single-ended mode
  second_analog_a: assert property (@(posedge ref_clk) disable iff (srst) // [R09]
    !ctrl.differential_mode_select
    |=> second_route.sidetone == $past(ctrl.sidetone_route_second_out)
      && second_route.buzzer == $past(ctrl.buzzer_route_second_out) // [R10]
      && second_route.keyclick == $past(ctrl.keyclick_route_second_out) // [R11]
      && second_route.cellin == $past(ctrl.cellin_route_second_out)) // [R12]
    else $error("second output analog routing mismatch");

  // Differential mode silences the second output entirely
  second_off_a: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
    ctrl.differential_mode_select
    |=> second_route == route_of(`ORC_DAC_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1))
    else $error("second output active in differential mode");

  // Both outputs leave reset muted
  mute_reset_a: assert property (@(posedge ref_clk) // [R13]
    $fell(srst) |-> first_route.mute && second_route.mute // [R14]
      && !hp_short_protect_disable) // [R15]
    else $error("outputs not muted after reset");

  // Second mute honoured in single-ended mode
  second_mute_a: assert property (@(posedge ref_clk) disable iff (srst) // [R14]
    !ctrl.differential_mode_select |=> second_route.mute == $past(ctrl.second_out_mute))
    else $error("second mute mismatch");

  // Written protection bit reaches the pin two edges later
  protect_write_a: assert property (@(posedge ref_clk) disable iff (srst) // [R15]
    wr_en && hit ##1 !srst |=> hp_short_protect_disable == $past(wr_data[0], 2))
    else $error("protection disable does not follow write");

  // A read answers next cycle with bit zero clear
  read_back_a: assert property (@(posedge ref_clk) disable iff (srst) // [R16]
    rd_en && hit |=> rd_valid && !rd_data[0]
      && rd_data[15:1] == $past(16'(ctrl) >> 1))
    else $error("read-back value wrong");

  // First mute follows its bit in either mode
  first_mute_a: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
    1'b1 |=> first_route.mute == $past(ctrl.first_out_mute))
    else $error("first mute mismatch");

  // A read of any other place still answers, with zero
  read_miss_a: assert property (@(posedge ref_clk) disable iff (srst) // [R16]
    rd_en && !hit |=> rd_valid && rd_data == `ORC_READ_NONE)
    else $error("unmapped read not zero");

endmodule : orc_output_routing

`default_nettype wire

// File: sim/output_routing_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "orc_params.svh"

module output_driver_routing_ctrl_tb;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic ref_clk = 1'b0; // 50 MHz system clock
  logic srst = 1'b1; // Held high for the first two edges
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] page = 4'h0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wr_data = 16'h0000;
  logic first_pwr_up = 1'b1; // Both drivers start powered
  logic aux_pwr_up = 1'b1;
  logic [15:0] rd_data;
  logic rd_valid;
  orc_pkg::orc_route_t first_route;
  orc_pkg::orc_route_t second_route;
  logic diff_mode;
  logic pair_power_down;
  logic hp_short_protect_disable;
  int n_mismatch = 0;
  int total_checks = 0;
  int model_reg = 16'h0006; // Reference copy of the stored word

  orc_output_routing orc_output_routing_i (
    .ref_clk(ref_clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en), .page(page),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .first_pwr_up(first_pwr_up), .aux_pwr_up(aux_pwr_up), .first_route(first_route),
    .second_route(second_route), .diff_mode(diff_mode), .pair_power_down(pair_power_down),
    .hp_short_protect_disable(hp_short_protect_disable)
  );

  // Free-running clock, 20 ns period
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------------------
  // Reference model and checking helpers
  // ---------------------------------------------------------------------------
  // Expected switch settings of one driver; the average code lights only dac_avg
  function automatic logic [7:0] route_of(input logic [15:0] r, input logic second);
    logic [5:0] f;
    logic m;
    f = second ? r[8:3] : r[14:9];
    m = second ? r[1] : r[2];
    return {f[5:4] == 2'h1, f[5:4] == 2'h2, f[5:4] == 2'h3, f[3:0], m};
  endfunction : route_of

  // One comparison; case inequality so an unknown never matches
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // Compare every driver control with the model
  task automatic chk_out;
    logic [15:0] r;
    logic [7:0] sec;
    r = model_reg[15:0];
    // Differential mode parks the second driver muted with no sources
    sec = r[15] ? 8'h01 : route_of(r, 1'b1);
    cmp({8'h00, first_route}, {8'h00, route_of(r, 1'b0)}, "first");
    cmp({8'h00, second_route}, {8'h00, sec}, "second");
    cmp({15'h0, diff_mode}, {15'h0, r[15]}, "mode");
    cmp({15'h0, pair_power_down}, {15'h0, r[15] & ~(first_pwr_up & aux_pwr_up)}, "pdn");
    cmp({15'h0, hp_short_protect_disable}, {15'h0, r[0]}, "hp");
  endtask : chk_out

  // Register write: one-cycle strobe, launched just after an edge
  task automatic wr(input logic [3:0] pg, input logic [5:0] ad, input logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    page <= pg;
    addr <= ad;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    // Only the mapped place updates the model
    if (pg == `ORC_REG_PAGE && ad == `ORC_REG_ADDR) begin
      model_reg = d;
    end
  endtask : wr

  // Register read: answer in the cycle after the strobe; rd_valid for one cycle only, rd_data held after
  task automatic rd(input logic [3:0] pg, input logic [5:0] ad, input logic [15:0] exp);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    page <= pg;
    addr <= ad;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    // The strobe was taken at this edge, so the answer stands now
    #1;
    cmp({15'h0, rd_valid}, 16'h0001, "rd_valid");
    cmp(rd_data, exp, "rd_data");
    @(posedge ref_clk);
    #1;
    cmp({15'h0, rd_valid}, 16'h0000, "rd_valid drop");
    cmp(rd_data, exp, "rd_data hold");
  endtask : rd

  // Outputs and the power sync need at most three edges; four gives margin
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle

  // Read back the stored word with the write-only bit hidden
  task automatic rd_reg;
    rd(`ORC_REG_PAGE, `ORC_REG_ADDR, model_reg[15:0] & 16'hFFFE);
  endtask : rd_reg

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(41187));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk_out();
    rd_reg();
    // Every DAC source code on both drivers, single-ended
    for (int c = 0; c < 4; c++) begin
      wr(`ORC_REG_PAGE, `ORC_REG_ADDR, {1'b0, 2'(c), 4'h0, 2'(c), 7'h00});
      settle();
      chk_out();
    end
    // Walking one in both modes covers every single-bit control
    for (int b = 0; b < 32; b++) begin
      wr(`ORC_REG_PAGE, `ORC_REG_ADDR, (16'h0001 << b[3:0]) | {b[4], 15'h0000});
      settle();
      chk_out();
      rd_reg();
    end
    // Unmapped page and offset: writes ignored, reads answer zero
    wr(4'h3, `ORC_REG_ADDR, 16'hFFFF);
    wr(`ORC_REG_PAGE, 6'h21, 16'hFFFF);
    settle();
    chk_out();
    rd(`ORC_REG_PAGE, 6'h21, 16'h0000);
    rd(4'h3, `ORC_REG_ADDR, 16'h0000);
    // Each power combination in differential mode
    wr(`ORC_REG_PAGE, `ORC_REG_ADDR, 16'h8004);
    for (int p = 0; p < 4; p++) begin
      @(posedge ref_clk);
      {first_pwr_up, aux_pwr_up} <= 2'(p);
      settle();
      chk_out();
    end
    // Random words and power states, two writes close together
    repeat (40) begin
      @(posedge ref_clk);
      {first_pwr_up, aux_pwr_up} <= 2'($urandom);
      wr(`ORC_REG_PAGE, `ORC_REG_ADDR, 16'($urandom));
      wr(`ORC_REG_PAGE, `ORC_REG_ADDR, 16'($urandom));
      settle();
      chk_out();
      rd_reg();
    end
    // Reset in mid-run restores the muted, protected state
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    model_reg = 16'h0006;
    settle();
    chk_out();
    rd_reg();
    complete_run();
  end

  // Watchdog, far beyond the expected run of about 850 cycles
  initial begin
    #400000;
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule : output_driver_routing_ctrl_tb

`default_nettype wire
